// file: rtl/bcq_pkg.sv
// Function
// [RULE1] partition config set answered with code 0xAC unless checksum or id bad
// [RULE2] 0xAC answer: header 0-15, codes 16-19, checksum 20-23, then pad
// [RULE3] controller may send boot config query, code 0x2D, for one protocol
// [RULE4] query for a protocol the destination lacks fails as unsupported
// [RULE5] query: header 0-15, reserved 16-19, protocol 20-23, checksum, pad to 45
// [RULE6] protocol type in bits 7..0: 0 PXE, 1 iSCSI, 2 FCoE, 3 FC, 4 NVMeoFC
// [RULE7] every query answered with code 0xAD unless checksum or id bad
// [RULE8] answer carries stored boot settings of the requested protocol
// [RULE9] supported attributes without value are sent with length 0
// [RULE10] attribute values are unterminated ASCII strings
// [RULE11] answer: codes 16-19, protocol and count 20-23, items from byte 28
// [RULE12] answer echoes protocol type and only that protocol's attributes
// [RULE13] item: type bits 7..0, length bits 15..8, then value; PXE codes 0,1
// [RULE14] iSCSI codes 0x0-0x7, 0x10-0x18, 0x20-0x28; rest reserved
// [RULE15] FC codes 0x0-0x4 used; 0x5-0xF reserved
// [RULE16] FCoE codes 0x0-0x4 used; 0x5-0xF reserved
// [RULE17] iSCSI target vlan enable items 0x17 and 0x27 are boolean
// [RULE18] item count field equals the items actually sent
package bcq_pkg;
    localparam int NENT = 8;
    localparam logic [7:0] MAXLEN = 8'h08;
    // command and response codes
    localparam logic [7:0] CMD_SET_PART = 8'h2c;
    localparam logic [7:0] CMD_GET_BOOT = 8'h2d;
    localparam logic [7:0] RSP_FLAG     = 8'h80;
    localparam logic [15:0] RC_OK       = 16'h0000;
    localparam logic [15:0] RC_UNSUP    = 16'h0003;
    localparam logic [15:0] RS_NONE     = 16'h0000;
    localparam logic [15:0] RS_UNSUP    = 16'h7fff;
    // boot protocol types
    localparam logic [7:0] PR_PXE   = 8'h00;
    localparam logic [7:0] PR_ISCSI = 8'h01;
    localparam logic [7:0] PR_FCOE  = 8'h02;
    localparam logic [7:0] PR_FC    = 8'h03;
    localparam logic [7:0] PR_NVME  = 8'h04;
    // attribute code limits
    localparam logic [7:0] PXE_MAX  = 8'h01;
    localparam logic [7:0] FC_MAX   = 8'h04;
    localparam logic [7:0] IS_I_MAX = 8'h07;
    localparam logic [7:0] IS_T1_LO = 8'h10;
    localparam logic [7:0] IS_T1_HI = 8'h18;
    localparam logic [7:0] IS_T2_LO = 8'h20;
    localparam logic [7:0] IS_T2_HI = 8'h28;
    localparam logic [7:0] first_target_vlan_on  = 8'h17;
    localparam logic [7:0] second_target_vlan_on = 8'h27;
    localparam logic [7:0] ASCII_0  = 8'h30;
    // byte offsets in the response
    localparam logic [7:0] OFS_IID   = 8'h03;
    localparam logic [7:0] OFS_RTYPE = 8'h04;
    localparam logic [7:0] OFS_HEND  = 8'h0f;
    localparam logic [7:0] OFS_CEND  = 8'h13;
    localparam logic [7:0] OFS_PROTO = 8'h16;
    localparam logic [7:0] OFS_CNT   = 8'h17;
    localparam logic [7:0] OFS_QEND  = 8'h1b;
    localparam logic [7:0] OFS_TLV   = 8'h1c;
    localparam logic [7:0] OFS_CK_AC = 8'h14;
    localparam logic [7:0] MIN_LAST  = 8'h2d;
    // register offsets and reset values
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SUPP = 8'h04;
    localparam logic [7:0] REG_SEL  = 8'h08;
    localparam logic [7:0] REG_META = 8'h0c;
    localparam logic [7:0] REG_DLO  = 8'h10;
    localparam logic [7:0] REG_DHI  = 8'h14;
    localparam logic [7:0] REG_STAT = 8'h18;
    localparam logic       CTRL_RST = 1'b1;
    localparam logic [4:0] SUPP_RST = 5'h1f;
    localparam int META_TYPE = 8;
    localparam int META_LEN  = 16;
    localparam int META_VLD  = 31;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] iid;
        logic [7:0] proto;
        logic       sum_ok;
        logic       id_ok;
    } bcq_cmd_t;

    typedef struct packed {
        logic        vld;
        logic [2:0]  proto;
        logic [7:0]  atype;
        logic [7:0]  len;
        logic [63:0] data;
    } bcq_ent_t;
endpackage : bcq_pkg

// file: rtl/bcq_responder.sv
`timescale 1ns/10ps
module bcq_responder
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [31:0]           reg_rdata,
    // parsed command
    input  wire logic             cmd_valid,
    output logic                  cmd_ready,
    input  wire bcq_pkg::bcq_cmd_t cmd,
    // response byte stream
    output logic                  rsp_valid,
    input  wire logic             rsp_ready,
    output logic [7:0]            rsp_data,
    output logic                  rsp_last
);
    import bcq_pkg::*;

    typedef enum logic [3:0]
    {
        S_IDLE, S_HDR, S_CODE, S_QW, S_TL0, S_TL1, S_VAL, S_ALN, S_CK, S_PAD
    } bcq_st_t;

    bcq_st_t     st_q, ost_q;
    bcq_cmd_t    cmd_q;
    bcq_ent_t    ent_q [NENT];
    logic        en_q, fail_q, vld_q, last_q;
    logic [4:0]  supp_q;
    logic [2:0]  sel_q, idx_q;
    logic [7:0]  pos_q, opos_q, vi_q, byte_q, cnt_q, tl_cnt_q;
    logic [7:0]  rcnt_q, dcnt_q;
    logic [31:0] sum_q, ck;
    logic        take, ok, unsup, adv, is_q, is_last;
    logic [7:0]  cur_byte, cur_len;
    logic [3:0]  nxt, first;

    ////////////////////////////////////////////////////////////////////////
    // attribute code legality per protocol
    function automatic logic attr_legal(logic [7:0] p, logic [7:0] t);
        logic r;
        r = 1'b0;
        unique case (p)
            PR_PXE:   r = t <= PXE_MAX;                            // RULE13
            PR_ISCSI: r = t <= IS_I_MAX                            // RULE14
                          || (t >= IS_T1_LO && t <= IS_T1_HI)
                          || (t >= IS_T2_LO && t <= IS_T2_HI);
            PR_FCOE:  r = t <= FC_MAX;                             // RULE16
            PR_FC:    r = t <= FC_MAX;                             // RULE15
            default:  r = 1'b0;                                    // RULE6
        endcase
        return r;
    endfunction : attr_legal

    // entry belongs to the requested protocol
    function automatic logic match(bcq_ent_t e, logic [7:0] p);
        return e.vld && {5'h00, e.proto} == p && attr_legal(p, e.atype);
    endfunction : match

    // boolean items
    function automatic logic is_bool(bcq_ent_t e);
        return e.proto == PR_ISCSI[2:0] && (e.atype == first_target_vlan_on
               || e.atype == second_target_vlan_on);
    endfunction : is_bool

    // length sent for an entry
    function automatic logic [7:0] tlv_len(bcq_ent_t e);
        if (is_bool(e) && e.len != 8'h00)
            return 8'h01;                                          // RULE17
        return e.len;                                              // RULE9
    endfunction : tlv_len

    // next matching entry at or after start, NENT when none
    function automatic logic [3:0] next_match(logic [3:0] s, logic [7:0] p);
        logic [3:0] r;
        r = 4'(NENT);
        for (int i = NENT - 1; i >= 0; i--)
            if (4'(i) >= s && match(ent_q[i], p))
                r = 4'(i);
        return r;
    endfunction : next_match

    // number of entries that will be sent for a protocol
    function automatic logic [7:0] count_match(logic [7:0] p);
        logic [7:0] n;
        n = 8'h00;
        for (int i = 0; i < NENT; i++)
            if (match(ent_q[i], p))
                n = n + 8'h01;
        return n;
    endfunction : count_match

    ////////////////////////////////////////////////////////////////////////
    // command acceptance
    assign cmd_ready = st_q == S_IDLE;
    assign take      = cmd_valid && cmd_ready;
    assign ok        = en_q && cmd.sum_ok && cmd.id_ok                // RULE1
                       && (cmd.code == CMD_SET_PART
                           || cmd.code == CMD_GET_BOOT);              // RULE7
    assign unsup     = cmd.code == CMD_GET_BOOT && (cmd.proto > PR_NVME
                       || !supp_q[cmd.proto[2:0]]);                   // RULE4
    assign is_q      = cmd_q.code == CMD_GET_BOOT;
    assign adv       = st_q != S_IDLE && (!vld_q || rsp_ready);
    assign ck        = ~sum_q + 32'h1;
    assign cur_len   = tlv_len(ent_q[idx_q]);
    assign nxt       = next_match(4'(idx_q) + 4'h1, cmd_q.proto);
    assign first     = next_match(4'h0, cmd_q.proto);

    // byte for the current position
    always_comb
    begin
        cur_byte = 8'h00;
        unique case (st_q)
            S_HDR:
                if (pos_q == OFS_IID)
                    cur_byte = cmd_q.iid;
                else if (pos_q == OFS_RTYPE)
                    cur_byte = cmd_q.code | RSP_FLAG;              // RULE1
            S_CODE:
                unique case (pos_q[1:0])
                    2'h0: cur_byte = fail_q ? RC_UNSUP[15:8] : RC_OK[15:8];
                    2'h1: cur_byte = fail_q ? RC_UNSUP[7:0] : RC_OK[7:0];
                    2'h2: cur_byte = fail_q ? RS_UNSUP[15:8] : RS_NONE[15:8];
                    2'h3: cur_byte = fail_q ? RS_UNSUP[7:0] : RS_NONE[7:0];
                endcase
            S_QW:
                if (pos_q == OFS_PROTO)
                    cur_byte = cmd_q.proto;                        // RULE12
                else if (pos_q == OFS_CNT)
                    cur_byte = fail_q ? 8'h00 : cnt_q;             // RULE18
            S_TL0: cur_byte = cur_len;                             // RULE13
            S_TL1: cur_byte = ent_q[idx_q].atype;
            S_VAL:
                if (is_bool(ent_q[idx_q]))
                    cur_byte = ASCII_0 | {7'h00, ent_q[idx_q].data[0]};
                else
                    cur_byte = ent_q[idx_q].data[vi_q[2:0]*8 +: 8]; // RULE10
            S_CK: cur_byte = ck[(5'd24 - {vi_q[1:0], 3'b000}) +: 8];
            default: cur_byte = 8'h00;
        endcase
    end

    assign is_last = (st_q == S_CK && vi_q == 8'h03 && pos_q >= MIN_LAST)
                     || (st_q == S_PAD && pos_q == MIN_LAST);      // RULE2

    ////////////////////////////////////////////////////////////////////////
    // response sequencer
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q  <= S_IDLE;
            pos_q <= 8'h00;
            vi_q  <= 8'h00;
            idx_q <= 3'h0;
        end
        else if (take)
        begin
            st_q  <= ok ? S_HDR : S_IDLE;
            pos_q <= 8'h00;
        end
        else if (adv)
        begin
            pos_q <= pos_q + 8'h01;
            vi_q  <= vi_q + 8'h01;
            unique case (st_q)
                S_HDR:
                    if (pos_q == OFS_HEND)
                        st_q <= S_CODE;
                S_CODE:
                    if (pos_q == OFS_CEND)
                    begin
                        st_q <= is_q ? S_QW : S_CK;                // RULE2
                        vi_q <= 8'h00;
                    end
                S_QW:
                    if (pos_q == OFS_QEND)
                    begin
                        st_q  <= (!fail_q && first != 4'(NENT))
                                 ? S_TL0 : S_CK;                   // RULE11
                        idx_q <= first[2:0];
                        vi_q  <= 8'h00;
                    end
                S_TL0: st_q <= S_TL1;
                S_TL1, S_VAL:
                begin
                    if (st_q == S_TL1 && cur_len != 8'h00)
                    begin
                        st_q <= S_VAL;
                        vi_q <= 8'h00;
                    end
                    else if (st_q == S_TL1 || vi_q + 8'h01 == cur_len)
                    begin
                        vi_q  <= 8'h00;
                        idx_q <= nxt[2:0];
                        if (nxt != 4'(NENT))
                            st_q <= S_TL0;                          // RULE8
                        else
                            st_q <= pos_q[1:0] == 2'h3 ? S_CK : S_ALN;
                    end
                end
                S_ALN:
                    if (pos_q[1:0] == 2'h3)
                    begin
                        st_q <= S_CK;
                        vi_q <= 8'h00;
                    end
                S_CK:
                    if (vi_q == 8'h03)
                        st_q <= is_last ? S_IDLE : S_PAD;
                S_PAD:
                    if (is_last)
                        st_q <= S_IDLE;
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // command latch and item count
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_q  <= '0;
            fail_q <= 1'b0;
            cnt_q  <= 8'h00;
        end
        else if (take)
        begin
            cmd_q  <= cmd;
            fail_q <= unsup;
            cnt_q  <= 8'h00;
        end
        else if (st_q == S_HDR && pos_q == 8'h00)
            cnt_q <= count_match(cmd_q.proto);                     // RULE18
    end

    // running checksum over 16-bit words
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            sum_q <= 32'h0;
        else if (take)
            sum_q <= 32'h0;
        else if (adv && st_q != S_CK && st_q != S_PAD)
            sum_q <= sum_q + (pos_q[0] ? {24'h0, cur_byte}
                                       : {16'h0, cur_byte, 8'h00});
    end

    // output byte holding stage
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vld_q  <= 1'b0;
            byte_q <= 8'h00;
            last_q <= 1'b0;
            ost_q  <= S_IDLE;
            opos_q <= 8'h00;
        end
        else if (adv)
        begin
            vld_q  <= 1'b1;
            byte_q <= cur_byte;
            last_q <= is_last;
            ost_q  <= st_q;
            opos_q <= pos_q;
        end
        else if (rsp_ready)
            vld_q <= 1'b0;
    end

    assign rsp_valid = vld_q;
    assign rsp_data  = byte_q;
    assign rsp_last  = last_q && vld_q;

    ////////////////////////////////////////////////////////////////////////
    // control registers and counters
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_q   <= CTRL_RST;
            supp_q <= SUPP_RST;
            sel_q  <= 3'h0;
            rcnt_q <= 8'h00;
            dcnt_q <= 8'h00;
        end
        else
        begin
            if (reg_wr && reg_addr == REG_CTRL)
                en_q <= reg_wdata[0];
            if (reg_wr && reg_addr == REG_SUPP)
                supp_q <= reg_wdata[4:0];
            if (reg_wr && reg_addr == REG_SEL)
                sel_q <= reg_wdata[2:0];
            if (take && ok)
                rcnt_q <= rcnt_q + 8'h01;
            if (take && !ok)
                dcnt_q <= dcnt_q + 8'h01;
        end
    end

    // stored boot attribute table
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < NENT; i++)
                ent_q[i] <= '0;
        end
        else if (reg_wr && reg_addr == REG_META)
        begin
            ent_q[sel_q].proto <= reg_wdata[2:0];
            ent_q[sel_q].atype <= reg_wdata[META_TYPE +: 8];
            ent_q[sel_q].len   <= reg_wdata[META_LEN +: 8] > MAXLEN
                                  ? MAXLEN : reg_wdata[META_LEN +: 8];
            ent_q[sel_q].vld   <= reg_wdata[META_VLD];
        end
        else if (reg_wr && reg_addr == REG_DLO)
            ent_q[sel_q].data[31:0] <= reg_wdata;
        else if (reg_wr && reg_addr == REG_DHI)
            ent_q[sel_q].data[63:32] <= reg_wdata;
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 32'h0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CTRL: reg_rdata <= {31'h0, en_q};
                REG_SUPP: reg_rdata <= {27'h0, supp_q};
                REG_SEL:  reg_rdata <= {29'h0, sel_q};
                REG_META: reg_rdata <= {ent_q[sel_q].vld, 7'h00,
                                        ent_q[sel_q].len, ent_q[sel_q].atype,
                                        5'h00, ent_q[sel_q].proto};
                REG_DLO:  reg_rdata <= ent_q[sel_q].data[31:0];
                REG_DHI:  reg_rdata <= ent_q[sel_q].data[63:32];
                REG_STAT: reg_rdata <= {8'h00, dcnt_q, rcnt_q, 7'h00,
                                        st_q != S_IDLE};
                default:  reg_rdata <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            tl_cnt_q <= 8'h00;
        else if (take)
            tl_cnt_q <= 8'h00;
        else if (adv && st_q == S_TL0)
            tl_cnt_q <= tl_cnt_q + 8'h01;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_accept_start: assert property (take && ok |-> ##[1:2] rsp_valid) // RULE7
        else $error("accepted command gave no response");
    a_drop_bad: assert property (take && !cmd.sum_ok |=> st_q == S_IDLE) // RULE1
        else $error("bad checksum command was answered");
    a_rsp_type: assert property (rsp_valid && ost_q == S_HDR
        && opos_q == OFS_RTYPE |-> rsp_data == (cmd_q.code | RSP_FLAG)) // RULE1
        else $error("wrong response type code");
    a_unsup_code: assert property (rsp_valid && ost_q == S_CODE && fail_q
        && opos_q == 8'h11 |-> rsp_data == RC_UNSUP[7:0]) // RULE4
        else $error("unsupported protocol not reported");
    a_proto_echo: assert property (rsp_valid && ost_q == S_QW
        && opos_q == OFS_PROTO |-> rsp_data == cmd_q.proto) // RULE12
        else $error("protocol type not echoed");
    a_count_match: assert property (adv && st_q == S_CK && vi_q == 8'h00
        && is_q && !fail_q |-> tl_cnt_q == cnt_q) // RULE18
        else $error("item count differs from items sent");
    a_tlv_start: assert property (adv && st_q == S_TL0 && tl_cnt_q == 8'h00
        |-> pos_q == OFS_TLV) // RULE11
        else $error("first item not at byte 28");
    a_tlv_legal: assert property (adv && st_q == S_TL0
        |-> match(ent_q[idx_q], cmd_q.proto)) // RULE14
        else $error("item of another protocol sent");
    a_ac_layout: assert property (adv && st_q == S_CK && vi_q == 8'h00
        && !is_q |-> pos_q == OFS_CK_AC) // RULE2
        else $error("checksum misplaced in 0xAC response");
    a_frame_len: assert property (rsp_last |-> opos_q >= MIN_LAST) // RULE2
        else $error("response frame too short");

    c_query_ok: cover property (rsp_valid && ost_q == S_VAL);
    c_query_fail: cover property (rsp_last && fail_q);
    c_set_part: cover property (rsp_last && !is_q);
    c_stall: cover property (rsp_valid && !rsp_ready ##1 rsp_valid);
endmodule : bcq_responder

// file: test/bcq_sink.sv
`timescale 1ns/10ps
// controller side that takes the response bytes
module bcq_sink
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // response stream
    input  wire logic       rsp_valid,
    output logic            rsp_ready,
    input  wire logic [7:0] rsp_data,
    input  wire logic       rsp_last
);
    logic [7:0] q [$];
    int         n_last = 0;
    int         stall = 0;

    ////////////////////////////////////////////////////////////////////////
    // random back-pressure, bytes kept in arrival order
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rsp_ready <= 1'b0;
        end
        else
        begin
            rsp_ready <= ($urandom % 100) >= stall;
            if (rsp_valid && rsp_ready)
            begin
                q.push_back(rsp_data);
                if (rsp_last)
                    n_last <= n_last + 1;
            end
        end
    end
endmodule : bcq_sink

// file: test/boot_config_query_responder_bench.sv
`timescale 1ns/10ps
module boot_config_query_responder_bench;
    import bcq_pkg::*;
    logic        mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, cmd_valid = 0;
    logic [7:0]  reg_addr = 0, iid, rsp_data;
    logic [31:0] reg_wdata = 0, reg_rdata, v;
    logic        cmd_ready, rsp_valid, rsp_ready, rsp_last;
    bcq_cmd_t    cmd = '0;
    int          bad_count = 0, cmp_count = 0, n_ans = 0, base = 0;
    logic [7:0]  e [$];
    logic        t_v [8] = '{default: 1'b0};
    logic [2:0]  t_pr [8] = '{0, 1, 1, 3, 2, 1, 0, 4};
    logic [7:0]  t_ty [8] = '{8'h01, 8'h17, 8'h27, 8'h05, 8'h04, 8'h18,
                              8'h02, 8'h00};
    logic [7:0]  t_ln [8];
    logic [63:0] t_dt [8];
    logic [4:0]  supp = 5'h1f;
    logic [7:0]  plist [7] = '{0, 1, 2, 3, 4, 5, 8'hff};

    // clock
    always #25 mclk = ~mclk;

    bcq_responder u_dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_data(rsp_data), .rsp_last(rsp_last));
    bcq_sink u_sink (.mclk(mclk), .arst_n(arst_n), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            bad_count++;
            $display("[ERR] %0t exp %h got %h", $time, x, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd

    // command held until taken
    task automatic send(input logic [7:0] c, p, input logic s, i);
        @(posedge mclk);
        iid = 8'($urandom);
        cmd       <= '{c, iid, p, s, i};
        cmd_valid <= 1'b1;
        @(negedge mclk);
        for (int k = 0; k < 3000 && cmd_ready !== 1'b1; k++)
            @(negedge mclk);
        chk(1, cmd_ready);
        @(posedge mclk);
        cmd_valid <= 1'b0;
    endtask : send

    function automatic logic legal(input logic [7:0] p, t);
        case (p)
            0: return t <= 8'h01;
            1: return t <= 8'h07 || (t >= 8'h10 && t <= 8'h18)
                   || (t >= 8'h20 && t <= 8'h28);
            2, 3: return t <= 8'h04;
            default: return 1'b0;
        endcase
    endfunction : legal

    task automatic push32(input logic [31:0] w);
        for (int k = 3; k >= 0; k--)
            e.push_back(w[8*k+:8]);
    endtask : push32

    // expected frame, then compared with what the sink took
    task automatic frame(input logic [7:0] c, p);
        logic [31:0] s;
        logic [7:0]  l, n;
        logic        u, b;
        s = 0;
        n = 0;
        e = {};
        for (int k = 0; k < 16; k++)
            e.push_back(k == 3 ? iid : k == 4 ? (c | 8'h80) : 8'h00);
        u = p > 4 || !supp[p[2:0]];
        push32((c == 8'h2d && u) ? 32'h00037fff : 32'h0);
        if (c == 8'h2d)
        begin
            push32({16'h0, p, 8'h00});
            push32(0);
            for (int i = 0; i < 8 && !u; i++)
                if (t_v[i] && t_pr[i] == p && legal(p, t_ty[i]))
                begin
                    l = t_ln[i];
                    b = (t_ty[i] == 8'h17 || t_ty[i] == 8'h27) && l != 0;
                    l = b ? 8'h01 : l;
                    e.push_back(l);
                    e.push_back(t_ty[i]);
                    for (int k = 0; k < l; k++)
                        e.push_back(b ? 8'h30 | t_dt[i][0] : t_dt[i][8*k+:8]);
                    n++;
                end
            e[23] = n;
            while (e.size() % 4)
                e.push_back(8'h00);
        end
        for (int k = 0; k < e.size(); k += 2)
            s += {e[k], e[k+1]};
        push32(-s);
        while (e.size() < 46)
            e.push_back(8'h00);
        for (int k = 0; k < 3000 && u_sink.n_last <= n_ans; k++)
            @(negedge mclk);
        chk(n_ans + 1, u_sink.n_last);
        chk(e.size(), u_sink.q.size() - base);
        foreach (e[k])
            chk(e[k], u_sink.q[base + k]);
        base += e.size();
        n_ans++;
    endtask : frame

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    // watchdog
    initial
    begin
        #2000000;
        bad_count++;
        stop_test();
    end

    // main sequence
    initial
    begin
        void'($urandom(35));
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        rd(8'h00, v);
        chk(32'h1, v);
        rd(8'h04, v);
        chk(32'h1f, v);
        rd(8'h40, v);
        chk(32'h0, v);
        $display("register test done");
        send(8'h2c, 8'h00, 1'b1, 1'b1);
        frame(8'h2c, 8'h00);
        $display("partition answer test done");
        for (int i = 0; i < 8; i++)
        begin
            t_ln[i] = (i == 5) ? 8'h00 : 8'($urandom % 10);
            t_dt[i] = {$urandom, $urandom};
            wr(8'h08, i);
            wr(8'h10, t_dt[i][31:0]);
            wr(8'h14, t_dt[i][63:32]);
            wr(8'h0c, {1'b1, 7'h0, t_ln[i], t_ty[i], 5'h0, t_pr[i]});
            t_ln[i] = t_ln[i] > 8 ? 8'h08 : t_ln[i];
            t_v[i] = 1'b1;
            rd(8'h0c, v);
            chk({1'b1, 7'h0, t_ln[i], t_ty[i], 5'h0, t_pr[i]}, v);
        end
        foreach (plist[j])
        begin
            u_sink.stall = j * 13;
            send(8'h2d, plist[j], 1'b1, 1'b1);
            frame(8'h2d, plist[j]);
        end
        $display("query test done");
        wr(8'h04, 32'h1d);
        supp = 5'h1d;
        send(8'h2d, 8'h01, 1'b1, 1'b1);
        frame(8'h2d, 8'h01);
        $display("unsupported test done");
        send(8'h2d, 8'h00, 1'b0, 1'b1);
        send(8'h2d, 8'h00, 1'b1, 1'b0);
        send(8'h2e, 8'h00, 1'b1, 1'b1);
        wr(8'h00, 32'h0);
        send(8'h2d, 8'h00, 1'b1, 1'b1);
        wr(8'h00, 32'h1);
        repeat (60) @(posedge mclk);
        chk(base, u_sink.q.size());
        rd(8'h18, v);
        chk({8'h00, 8'h04, n_ans[7:0], 8'h00}, v);
        $display("drop test done");
        stop_test();
    end
endmodule : boot_config_query_responder_bench
